// >>> ppfs_cfg.svh
// Function
// - port A bit 3 code 11 drives timer output
// - port A bit 1 code 11 drives EL output
// - port A bit 4 code 11 drives inverted timer
// - port B bits 7..4 code 11 select segments 11..8
// - port C bits 3..0 code 11 select segments 3..0
// - port C bits 7..4 code 11 select segments 7..4
// - unimplemented selector bits ignore writes, read zero
// - reset sets data and direction bits to one
// - output enable with unwritten latch drives high
// - bit set/clear rewrites whole port byte
// - falling enabled port A pin wakes halted device
// - wake enable individual per port A pin
// - second timer pin is inverse of first
// - direction one is input, zero is output
// - output bit reads latch, not pin level
// - wake only when pin is I/O and halted
// - pull-high only for input pins
`ifndef PPFS_CFG_SVH
`define PPFS_CFG_SVH
`define PPFS_A_PA_DATA 4'h0
`define PPFS_A_PA_DIR  4'h1
`define PPFS_A_PA_PU   4'h2
`define PPFS_A_PA_WAKE 4'h3
`define PPFS_A_PB_DATA 4'h4
`define PPFS_A_PB_DIR  4'h5
`define PPFS_A_PB_PU   4'h6
`define PPFS_A_PC_DATA 4'h7
`define PPFS_A_PC_DIR  4'h8
`define PPFS_A_PC_PU   4'h9
`define PPFS_A_SEL_AL  4'hA
`define PPFS_A_SEL_AH  4'hB
`define PPFS_A_SEL_BH  4'hC
`define PPFS_A_SEL_CL  4'hD
`define PPFS_A_SEL_CH  4'hE
`define PPFS_A_BITOP   4'hF
`define PPFS_MASK_AL   8'hCC
`define PPFS_MASK_AH   8'h03
`define PPFS_RST_PORT  8'hFF
`define PPFS_RST_SEL   8'h00
`define PPFS_SEL_ALT   2'h3
`endif

// >>> ppfs_pin_model.sv
`timescale 1ns/1ps
module ppfs_pin_model (
	input  wire logic        clk,
	input  wire logic [23:0] drv_out,
	input  wire logic [23:0] drv_oe,
	input  wire logic [23:0] drv_pu,
	input  wire logic [23:0] ext_en,
	input  wire logic [23:0] ext_lvl,
	output logic      [23:0] pin_lvl
);
	logic flt_reg;
	initial flt_reg = 1'b0;
	// undriven, unpulled pin wanders
	always @(posedge clk) begin
		flt_reg <= ~flt_reg;
	end
	// chip drive wins, then outside driver, then pull-high
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			pin_lvl[i] = drv_oe[i] ? drv_out[i] : ext_en[i] ? ext_lvl[i] :
				drv_pu[i] ? 1'b1 : flt_reg;
		end
	end
endmodule

// >>> ppfs_pin_slice.sv
`timescale 1ns/1ps
`include "ppfs_cfg.svh"
module ppfs_pin_slice (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] latch,
	input  wire logic [7:0] dir,
	input  wire logic [7:0] pu,
	input  wire logic [7:0] alt_en,
	input  wire logic [7:0] alt_val,
	input  wire logic [7:0] pin_in,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe,
	output logic      [7:0] pin_pu,
	output logic      [7:0] rd_val
);
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
	} ppfs_slice_t;
	ppfs_slice_t s_reg;
	ppfs_slice_t s_next;

	always_comb begin
		s_next.oe  = alt_en | ~dir;
		s_next.out = (alt_en & alt_val) | (~alt_en & latch);
		s_next.pu  = pu & dir & ~alt_en;
		if (reset) begin
			s_next.out = 8'h00;
			s_next.oe  = 8'h00;
			s_next.pu  = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign pin_out = s_reg.out;
	assign pin_oe  = s_reg.oe;
	assign pin_pu  = s_reg.pu;
	assign rd_val  = (dir & pin_in) | (~dir & latch);

	AST_PU_INPUT_ONLY: assert property (@(posedge clk) disable iff (reset)
		(s_reg.pu & s_reg.oe) == 8'h00) else $error("pull-high on driven pin");
endmodule

// >>> ppfs_pkg.sv
package ppfs_pkg;
	typedef enum logic [1:0] {
		PPFS_PORT_A,
		PPFS_PORT_B,
		PPFS_PORT_C,
		PPFS_PORT_NONE
	} ppfs_port_t;
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
		logic [7:0] pu;
	} ppfs_port_regs_t;
endpackage

// >>> ppfs_top.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "ppfs_cfg.svh"
module ppfs_top (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       halted,
	input  wire logic       timer_output,
	input  wire logic       el_drive_output,
	input  wire logic [11:0] lcd_segment_line,
	input  wire logic [7:0] pa_in,
	input  wire logic [7:0] pb_in,
	input  wire logic [7:0] pc_in,
	output logic      [7:0] pa_out,
	output logic      [7:0] pa_oe,
	output logic      [7:0] pa_pu,
	output logic      [7:0] pb_out,
	output logic      [7:0] pb_oe,
	output logic      [7:0] pb_pu,
	output logic      [7:0] pc_out,
	output logic      [7:0] pc_oe,
	output logic      [7:0] pc_pu,
	output logic            wake
);
	typedef struct packed {
		ppfs_pkg::ppfs_port_regs_t pa;
		ppfs_pkg::ppfs_port_regs_t pb;
		ppfs_pkg::ppfs_port_regs_t pc;
		logic [7:0] porta_wake_enable;
		logic [7:0] sel_al;
		logic [7:0] sel_ah;
		logic [7:0] sel_bh;
		logic [7:0] sel_cl;
		logic [7:0] sel_ch;
		logic [7:0] rdata;
	} ppfs_state_t;
	ppfs_state_t st_reg;
	ppfs_state_t st_next;

	logic [7:0] alt_a;
	logic [7:0] alt_b;
	logic [7:0] alt_c;
	logic [7:0] val_a;
	logic [7:0] val_b;
	logic [7:0] val_c;
	logic [7:0] rd_a;
	logic [7:0] rd_b;
	logic [7:0] rd_c;
	logic [3:0] hit_al;
	logic [3:0] hit_ah;

	function automatic logic [3:0] sel_alt(input logic [7:0] s);
		sel_alt[0] = s[1:0] == `PPFS_SEL_ALT;
		sel_alt[1] = s[3:2] == `PPFS_SEL_ALT;
		sel_alt[2] = s[5:4] == `PPFS_SEL_ALT;
		sel_alt[3] = s[7:6] == `PPFS_SEL_ALT;
	endfunction

	function automatic logic [7:0] bit_op(input logic [7:0] v, input logic [2:0] b,
		input logic set);
		logic [7:0] r;
		r    = v;
		r[b] = set;
		bit_op = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin function routing
	always_comb begin
		hit_al   = sel_alt(st_reg.sel_al);
		hit_ah   = sel_alt(st_reg.sel_ah);
		alt_a    = 8'h00;
		val_a    = 8'h00;
		alt_a[3] = hit_al[3];
		val_a[3] = timer_output;
		alt_a[1] = hit_al[1];
		val_a[1] = el_drive_output;
		alt_a[4] = hit_ah[0];
		val_a[4] = ~timer_output;
		alt_b    = {sel_alt(st_reg.sel_bh), 4'h0};
		val_b    = {lcd_segment_line[11:8], 4'h0};
		alt_c    = {sel_alt(st_reg.sel_ch), sel_alt(st_reg.sel_cl)};
		val_c    = lcd_segment_line[7:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// register file
	always_comb begin
		logic [7:0] cur;
		ppfs_pkg::ppfs_port_t tgt;
		cur     = 8'h00;
		tgt     = ppfs_pkg::PPFS_PORT_NONE;
		st_next = st_reg;
		if (wr) begin
			unique case (addr)
				`PPFS_A_PA_DATA: st_next.pa.data = wdata;
				`PPFS_A_PA_DIR: st_next.pa.dir = wdata;
				`PPFS_A_PA_PU: st_next.pa.pu = wdata;
				`PPFS_A_PA_WAKE: st_next.porta_wake_enable = wdata;
				`PPFS_A_PB_DATA: st_next.pb.data = wdata;
				`PPFS_A_PB_DIR: st_next.pb.dir = wdata;
				`PPFS_A_PB_PU: st_next.pb.pu = wdata;
				`PPFS_A_PC_DATA: st_next.pc.data = wdata;
				`PPFS_A_PC_DIR: st_next.pc.dir = wdata;
				`PPFS_A_PC_PU: st_next.pc.pu = wdata;
				`PPFS_A_SEL_AL: st_next.sel_al = wdata & `PPFS_MASK_AL;
				`PPFS_A_SEL_AH: st_next.sel_ah = wdata & `PPFS_MASK_AH;
				`PPFS_A_SEL_BH: st_next.sel_bh = wdata;
				`PPFS_A_SEL_CL: st_next.sel_cl = wdata;
				`PPFS_A_SEL_CH: st_next.sel_ch = wdata;
				`PPFS_A_BITOP: begin
					// wdata[7]=set, [5:4]=port, [3]=direction reg, [2:0]=bit
					tgt = ppfs_pkg::ppfs_port_t'(wdata[5:4]);
					unique case (tgt)
						ppfs_pkg::PPFS_PORT_A: cur = wdata[3] ? st_reg.pa.dir : rd_a;
						ppfs_pkg::PPFS_PORT_B: cur = wdata[3] ? st_reg.pb.dir : rd_b;
						ppfs_pkg::PPFS_PORT_C: cur = wdata[3] ? st_reg.pc.dir : rd_c;
						ppfs_pkg::PPFS_PORT_NONE: cur = 8'h00;
					endcase
					cur = bit_op(cur, wdata[2:0], wdata[7]);
					unique case (tgt)
						ppfs_pkg::PPFS_PORT_A: begin
							if (wdata[3]) st_next.pa.dir = cur;
							else st_next.pa.data = cur;
						end
						ppfs_pkg::PPFS_PORT_B: begin
							if (wdata[3]) st_next.pb.dir = cur;
							else st_next.pb.data = cur;
						end
						ppfs_pkg::PPFS_PORT_C: begin
							if (wdata[3]) st_next.pc.dir = cur;
							else st_next.pc.data = cur;
						end
						ppfs_pkg::PPFS_PORT_NONE: begin
						end
					endcase
				end
				default: begin
				end
			endcase
		end
		st_next.rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				`PPFS_A_PA_DATA: st_next.rdata = rd_a;
				`PPFS_A_PA_DIR: st_next.rdata = st_reg.pa.dir;
				`PPFS_A_PA_PU: st_next.rdata = st_reg.pa.pu;
				`PPFS_A_PA_WAKE: st_next.rdata = st_reg.porta_wake_enable;
				`PPFS_A_PB_DATA: st_next.rdata = rd_b;
				`PPFS_A_PB_DIR: st_next.rdata = st_reg.pb.dir;
				`PPFS_A_PB_PU: st_next.rdata = st_reg.pb.pu;
				`PPFS_A_PC_DATA: st_next.rdata = rd_c;
				`PPFS_A_PC_DIR: st_next.rdata = st_reg.pc.dir;
				`PPFS_A_PC_PU: st_next.rdata = st_reg.pc.pu;
				`PPFS_A_SEL_AL: st_next.rdata = st_reg.sel_al;
				`PPFS_A_SEL_AH: st_next.rdata = st_reg.sel_ah;
				`PPFS_A_SEL_BH: st_next.rdata = st_reg.sel_bh;
				`PPFS_A_SEL_CL: st_next.rdata = st_reg.sel_cl;
				`PPFS_A_SEL_CH: st_next.rdata = st_reg.sel_ch;
				default: st_next.rdata = 8'h00;
			endcase
		end
		if (reset) begin
			st_next.pa = {`PPFS_RST_PORT, `PPFS_RST_PORT, 8'h00};
			st_next.pb = {`PPFS_RST_PORT, `PPFS_RST_PORT, 8'h00};
			st_next.pc = {`PPFS_RST_PORT, `PPFS_RST_PORT, 8'h00};
			st_next.porta_wake_enable = 8'h00;
			st_next.sel_al = `PPFS_RST_SEL;
			st_next.sel_ah = `PPFS_RST_SEL;
			st_next.sel_bh = `PPFS_RST_SEL;
			st_next.sel_cl = `PPFS_RST_SEL;
			st_next.sel_ch = `PPFS_RST_SEL;
			st_next.rdata = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	assign rdata = st_reg.rdata;

	////////////////////////////////////////////////////////////////////////////
	// pin slices and wake-up
	ppfs_pin_slice u_pa (
		.clk    (clk),
		.reset  (reset),
		.latch  (st_reg.pa.data),
		.dir    (st_reg.pa.dir),
		.pu     (st_reg.pa.pu),
		.alt_en (alt_a),
		.alt_val(val_a),
		.pin_in (pa_in),
		.pin_out(pa_out),
		.pin_oe (pa_oe),
		.pin_pu (pa_pu),
		.rd_val (rd_a)
	);
	ppfs_pin_slice u_pb (
		.clk    (clk),
		.reset  (reset),
		.latch  (st_reg.pb.data),
		.dir    (st_reg.pb.dir),
		.pu     (st_reg.pb.pu),
		.alt_en (alt_b),
		.alt_val(val_b),
		.pin_in (pb_in),
		.pin_out(pb_out),
		.pin_oe (pb_oe),
		.pin_pu (pb_pu),
		.rd_val (rd_b)
	);
	ppfs_pin_slice u_pc (
		.clk    (clk),
		.reset  (reset),
		.latch  (st_reg.pc.data),
		.dir    (st_reg.pc.dir),
		.pu     (st_reg.pc.pu),
		.alt_en (alt_c),
		.alt_val(val_c),
		.pin_in (pc_in),
		.pin_out(pc_out),
		.pin_oe (pc_oe),
		.pin_pu (pc_pu),
		.rd_val (rd_c)
	);
	ppfs_wake u_wake (
		.clk      (clk),
		.reset    (reset),
		.halted   (halted),
		.enable   (st_reg.porta_wake_enable),
		.gpio_mode(~alt_a),
		.pin_in   (pa_in),
		.wake     (wake)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	AST_PA3_TIMER: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_al[7:6] == 2'h3 |=> pa_out[3] == $past(timer_output) && pa_oe[3])
		else $error("pa3 not timer");
	AST_PA1_EL: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_al[3:2] == 2'h3 |=> pa_out[1] == $past(el_drive_output))
		else $error("pa1 not el");
	AST_PA1_DRIVE: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_al[3:2] == 2'h3 |=> pa_oe[1])
		else $error("pa1 alternate not driven");
	AST_PA4_INV: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_ah[1:0] == 2'h3 |=> pa_out[4] == !$past(timer_output))
		else $error("pa4 not inverted timer");
	AST_PA4_DRIVE: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_ah[1:0] == 2'h3 |=> pa_oe[4])
		else $error("pa4 alternate not driven");
	AST_PB_SEG: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_bh[7:6] == 2'h3 |=> pb_out[7] == $past(lcd_segment_line[11]))
		else $error("pb7 not seg11");
	AST_PB_DRIVE: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_bh[7:6] == 2'h3 |=> pb_oe[7])
		else $error("pb7 segment not driven");
	AST_PC_SEG: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_cl[1:0] == 2'h3 && st_reg.sel_ch[7:6] == 2'h3
		|=> pc_out[0] == $past(lcd_segment_line[0]) && pc_out[7] == $past(lcd_segment_line[7]))
		else $error("pc seg routing");
	AST_PC_SEG_LOW: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_cl[7:6] == 2'h3 |=> pc_out[3] == $past(lcd_segment_line[3]))
		else $error("pc3 not seg3");
	AST_PC_HIGH_DRIVE: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_ch[7:6] == 2'h3 |=> pc_oe[7])
		else $error("pc7 segment not driven");
	AST_PC_GPIO_KEEP: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_cl[1:0] != 2'h3 && st_reg.pc.dir[0] |=> !pc_oe[0])
		else $error("pc0 driven while gpio input");
	AST_SEL_MASK: assert property (@(posedge clk) disable iff (reset)
		rd && addr == `PPFS_A_SEL_AH |=> rdata[7:2] == 6'h00)
		else $error("unimplemented selector bits read nonzero");
	AST_SEL_AL_MASK: assert property (@(posedge clk) disable iff (reset)
		rd && addr == `PPFS_A_SEL_AL |=> (rdata & 8'h33) == 8'h00)
		else $error("unimplemented low selector bits read nonzero");
	AST_RESET_HIGH: assert property (@(posedge clk)
		$fell(reset) |-> st_reg.pa.data == 8'hFF && st_reg.pc.dir == 8'hFF)
		else $error("port reset value");
	AST_GPIO_LATCH: assert property (@(posedge clk) disable iff (reset)
		st_reg.sel_bh == 8'h00 && st_reg.pb.dir == 8'h00 |=> pb_out == $past(st_reg.pb.data))
		else $error("gpio latch not driven");
	AST_BITOP_ONE_BIT: assert property (@(posedge clk) disable iff (reset)
		wr && addr == `PPFS_A_BITOP |=> $countones({st_reg.pa.dir, st_reg.pb.dir, st_reg.pc.dir}
		^ $past({st_reg.pa.dir, st_reg.pb.dir, st_reg.pc.dir})) <= 1)
		else $error("bit operation changed several direction bits");
	AST_WAKE_GPIO_ONLY: assert property (@(posedge clk) disable iff (reset)
		wake |-> $past((st_reg.porta_wake_enable & ~alt_a) != 8'h00))
		else $error("wake without enabled gpio pin");
	AST_DIR_OUT: assert property (@(posedge clk) disable iff (reset)
		st_reg.pb.dir == 8'h00 |=> pb_oe == 8'hFF)
		else $error("output direction not driven");
	AST_DIR_IN: assert property (@(posedge clk) disable iff (reset)
		st_reg.pa.dir == 8'hFF && alt_a == 8'h00 |=> pa_oe == 8'h00)
		else $error("input direction driven");
	AST_PU_OFF: assert property (@(posedge clk) disable iff (reset)
		st_reg.pa.pu == 8'h00 |=> pa_pu == 8'h00)
		else $error("pull-high without enable");
	COV_TIMER: cover property (@(posedge clk) disable iff (reset) st_reg.sel_al[7:6] == 2'h3);
	COV_SEG_B: cover property (@(posedge clk) disable iff (reset) st_reg.sel_bh == 8'hFF);
	COV_SEG: cover property (@(posedge clk) disable iff (reset) st_reg.sel_cl == 8'hFF);
	COV_BITOP: cover property (@(posedge clk) disable iff (reset) wr && addr == `PPFS_A_BITOP);
endmodule

// >>> ppfs_top_bench.sv
`timescale 1ns/1ps
module ppfs_top_bench;
	logic        clk, reset, wr, rd, halted, timer_output, el_drive_output, wake;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata;
	logic [11:0] lcd_segment_line;
	logic [7:0]  pa_out, pa_oe, pa_pu, pb_out, pb_oe, pb_pu, pc_out, pc_oe, pc_pu;
	logic [23:0] ext_en, ext_lvl, pin_lvl;
	logic [7:0]  rst_exp [16];
	int          failures, compares;

	ppfs_top DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .halted(halted), .timer_output(timer_output),
		.el_drive_output(el_drive_output), .lcd_segment_line(lcd_segment_line),
		.pa_in(pin_lvl[7:0]), .pb_in(pin_lvl[15:8]), .pc_in(pin_lvl[23:16]),
		.pa_out(pa_out), .pa_oe(pa_oe), .pa_pu(pa_pu), .pb_out(pb_out), .pb_oe(pb_oe),
		.pb_pu(pb_pu), .pc_out(pc_out), .pc_oe(pc_oe), .pc_pu(pc_pu), .wake(wake));

	ppfs_pin_model PINS (.clk(clk), .drv_out({pc_out, pb_out, pa_out}),
		.drv_oe({pc_oe, pb_oe, pa_oe}), .drv_pu({pc_pu, pb_pu, pa_pu}),
		.ext_en(ext_en), .ext_lvl(ext_lvl), .pin_lvl(pin_lvl));

	////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// count wake pulses after a port A pin change
	task wake_cnt(input logic [7:0] pa, input logic [7:0] e);
		int n;
		n = 0;
		@(posedge clk);
		ext_lvl[7:0] <= pa;
		repeat (8) begin
			@(posedge clk);
			#1 if (wake === 1'b1) n++;
		end
		chk("wake", e, 8'(n));
	endtask
	task test_done;
		if (failures == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#1000000;
		failures++;
		test_done;
	end

	////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		halted = 1'b0;
		timer_output = 1'b0;
		el_drive_output = 1'b0;
		lcd_segment_line = 12'h000;
		ext_lvl = 24'h3CA55A;
		ext_en = 24'hFFFFFF;
		failures = 0;
		compares = 0;
		rst_exp = '{8'h5A, 8'hFF, 8'h00, 8'h00, 8'hA5, 8'hFF, 8'h00, 8'h3C,
			8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 16; i++) rd_chk(4'(i), rst_exp[i]);
		chk("pa_oe", 8'h00, pa_oe);
		chk("pb_pu", 8'h00, pb_pu);
		// output with untouched latch
		wr_reg(4'h1, 8'h00);
		settle;
		chk("pa_oe", 8'hFF, pa_oe);
		chk("pa_out", 8'hFF, pa_out);
		rd_chk(4'h0, 8'hFF);
		// unimplemented selector bits
		wr_reg(4'hA, 8'hFF);
		rd_chk(4'hA, 8'hCC);
		wr_reg(4'hB, 8'hFF);
		rd_chk(4'hB, 8'h03);
		// port A alternate functions, every code
		wr_reg(4'h0, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr_reg(4'hA, {2'(c), 2'b00, 2'(c), 2'b00});
			wr_reg(4'hB, {6'h00, 2'(c)});
			timer_output <= 1'b1;
			el_drive_output <= 1'b1;
			settle;
			chk("pa_out", (c == 3) ? 8'h0A : 8'h00, pa_out);
			@(posedge clk);
			timer_output <= 1'b0;
			el_drive_output <= 1'b0;
			settle;
			chk("pa_out", (c == 3) ? 8'h10 : 8'h00, pa_out);
		end
		wr_reg(4'hA, 8'h00);
		wr_reg(4'hB, 8'h00);
		// port B mixed direction and bit operations
		wr_reg(4'h5, 8'h0F);
		wr_reg(4'h4, 8'h5A);
		ext_lvl[15:8] <= 8'hA4;
		rd_chk(4'h4, 8'h54);
		wr_reg(4'hF, 8'h90);
		rd_chk(4'h4, 8'h54);
		wr_reg(4'hF, 8'h1B);
		rd_chk(4'h5, 8'h07);
		wr_reg(4'h5, 8'h00);
		settle;
		chk("pb_out", 8'h55, pb_out);
		chk("pb_oe", 8'hFF, pb_oe);
		// pull-high follows direction
		wr_reg(4'h2, 8'hFF);
		settle;
		chk("pa_pu", 8'h00, pa_pu);
		wr_reg(4'h1, 8'h0F);
		settle;
		chk("pa_pu", 8'h0F, pa_pu);
		// released inputs fall back to the pull-high
		@(posedge clk);
		ext_en[7:0] <= 8'h00;
		rd_chk(4'h0, 8'h0F);
		@(posedge clk);
		ext_en[7:0] <= 8'hFF;
		// segment lines
		lcd_segment_line <= 12'hA5C;
		wr_reg(4'hC, 8'hFF);
		wr_reg(4'hD, 8'hFF);
		wr_reg(4'hE, 8'hFF);
		settle;
		chk("pb_out", 8'hA5, pb_out);
		chk("pc_out", 8'h5C, pc_out);
		chk("pc_oe", 8'hFF, pc_oe);
		wr_reg(4'hD, 8'hAA);
		wr_reg(4'h9, 8'hFF);
		settle;
		chk("pc_oe", 8'hF0, pc_oe);
		chk("pc_pu", 8'h0F, pc_pu);
		@(posedge clk);
		lcd_segment_line <= 12'h5A3;
		settle;
		chk("pb_out", 8'h55, pb_out);
		chk("pc_out_driven", 8'hA0, pc_out & pc_oe);
		// port A wake-up
		wr_reg(4'h1, 8'hFF);
		wr_reg(4'h3, 8'h14);
		wake_cnt(8'hFF, 8'h00);
		@(posedge clk);
		halted <= 1'b1;
		wake_cnt(8'hFB, 8'h01);
		wake_cnt(8'hFF, 8'h00);
		wake_cnt(8'hEF, 8'h01);
		wake_cnt(8'hEE, 8'h00);
		wake_cnt(8'hFF, 8'h00);
		@(posedge clk);
		halted <= 1'b0;
		wake_cnt(8'hFB, 8'h00);
		wake_cnt(8'hFF, 8'h00);
		@(posedge clk);
		halted <= 1'b1;
		wr_reg(4'hB, 8'h03);
		timer_output <= 1'b1;
		wake_cnt(8'hFF, 8'h00);
		// reset again in mid-run
		@(posedge clk);
		reset <= 1'b1;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		rd_chk(4'hB, 8'h00);
		rd_chk(4'h5, 8'hFF);
		settle;
		chk("pa_oe", 8'h00, pa_oe);
		chk("pb_oe", 8'h00, pb_oe);
		test_done;
	end
endmodule

// >>> ppfs_wake.sv
`timescale 1ns/1ps
module ppfs_wake (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       halted,
	input  wire logic [7:0] enable,
	input  wire logic [7:0] gpio_mode,
	input  wire logic [7:0] pin_in,
	output logic            wake
);
	typedef struct packed {
		logic [7:0] prev;
		logic       wake;
	} ppfs_wake_state_t;
	ppfs_wake_state_t w_reg;
	ppfs_wake_state_t w_next;

	always_comb begin
		w_next.prev = pin_in;
		w_next.wake = halted && |(w_reg.prev & ~pin_in & enable & gpio_mode);
		if (reset) begin
			w_next.prev = 8'hFF;
			w_next.wake = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		w_reg <= w_next;
	end

	assign wake = w_reg.wake;

	AST_WAKE_CAUSE: assert property (@(posedge clk) disable iff (reset)
		$rose(wake) |-> $past(halted)) else $error("wake while not halted");
	COV_WAKE: cover property (@(posedge clk) disable iff (reset) wake);
endmodule
